/* hw/ffrp_pkg.sv */
// constants for the flash function and read-parameter register block
// assumes a single-line serial host and a 10 MHz system clock sampling the link
package ffrp_pkg;
  // opcodes decoded from the serial link
  localparam logic [7:0] OPC_SET_RP_NV   = 8'h65; // set_read_params_nonvolatile_cmd
  localparam logic [7:0] OPC_SET_RP_V_A  = 8'hc0; // set_read_params_volatile_cmd
  localparam logic [7:0] OPC_SET_RP_V_B  = 8'h63; // set_read_params_volatile_cmd, alias
  localparam logic [7:0] OPC_WR_FUNC     = 8'h42; // write function register
  // function register fields
  localparam int FN_DED_RST_DIS = 0;
  localparam int FN_TOP_BOTTOM  = 1;
  localparam int FN_PGM_SUSP    = 2;
  localparam int FN_ERS_SUSP    = 3;
  localparam int FN_IR_LOCK_LO  = 4;
  localparam logic [7:0] FN_OTP_MASK = 8'hf3; // bits that only ever go to one
  // read-parameter fields
  localparam int RP_PIN_SEL = 7;
  localparam int RP_DUMMY_HI = 6;
  localparam int RP_DUMMY_LO = 3;
  localparam int RP_WRAP    = 2;
  localparam int RP_BURST_HI = 1;
  localparam int RP_BURST_LO = 0;
  localparam logic [7:0] RP_RESET = 8'h00;
  // default dummy counts when the dummy field is zero
  localparam logic [3:0] DUMMY_DEF_FAST_SPI = 4'h8;
  localparam logic [3:0] DUMMY_DEF_FAST_QPI = 4'h6;
  localparam logic [3:0] DUMMY_ZERO         = 4'h0;
  // burst length base: 8 bytes shifted by the two-bit code
  localparam logic [6:0] BURST_BASE = 7'h08;
  // serial frame: eight opcode bits then eight data bits
  localparam logic [3:0] BIT_OPC_LAST  = 4'h7;
  localparam logic [3:0] BIT_DATA_LAST = 4'hf;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_OPC  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_SKIP = 4'b1000
  } ffrp_state_t;
endpackage : ffrp_pkg

/* hw/ffrp_regs.sv */
// function register and read-parameter register pair of a serial flash
// assumes SCK, CE_N and SI come from the host unsynchronised; mode 0 sampling
// on SCK rising edges; suspend, resume and program requests come from core logic
// on CLK_SYS.
// all outputs are registered and lag the internal state by one system cycle;
// the link must be slow: each SCK level lasts at least two system cycles.
//
// Overview of operation
// RULE_01 - one-time bits of the function register never return to zero
// RULE_02 - function bit 0 disables the dedicated reset pin; default set per variant
// RULE_03 - function bit 1 selects bottom protection; cannot go back to top
// RULE_04 - program-suspend flag set on suspend during program, cleared on resume
// RULE_05 - erase-suspend flag set on suspend during erase, cleared on resume
// RULE_06 - function bits 4..7 lock information rows zero to three permanently
// RULE_07 - volatile read parameters load from the non-volatile copy at power-up
// RULE_08 - parameter bit 7 selects hold (0) or reset (1) on shared pin
// RULE_09 - with quad enable or quad command mode, bit 7 ignored; pin is data
// RULE_10 - dedicated reset still enabled forces hold on the shared pin
// RULE_11 - opcode 65h writes non-volatile copy, C0h or 63h the volatile copy
// RULE_12 - parameter bits 6..3 give dummy cycles one to fifteen when nonzero
// RULE_13 - zero dummy field means defaults: 8 single-line, 6 quad command mode
// RULE_14 - parameter bits 1..0 give burst length 8, 16, 32 or 64 bytes
// RULE_15 - parameter bit 2 set wraps within burst, clear wraps at array end
// RULE_16 - all read-parameter bits reset to zero
// RULE_17 - quad enable turns write-protect and shared pins into data lines 2, 3
// RULE_18 - reads follow the volatile copy; volatile writes leave non-volatile alone
// RULE_19 - program requests to a locked information row are refused
`timescale 1ns/100ps
module ffrp_regs #(
  parameter bit HAS_DEDICATED_RESET = 1'b1,   // package variant has its own reset pin
  parameter bit DED_RESET_DIS_INIT  = 1'b0    // variant default of function bit 0
) (
  input  wire logic       CLK_SYS,            // system clock, 10 MHz
  input  wire logic       RESET,              // synchronous reset, power-up
  input  wire logic       SCK,                // serial clock from host, async
  input  wire logic       CE_N,               // chip enable from host, active low, async
  input  wire logic       SI,                 // serial data in from host, async
  input  wire logic       QUAD_ENABLE,        // status register quad enable bit
  input  wire logic       QUAD_CMD_MODE,      // device is in quad command mode
  input  wire logic       PGM_ACTIVE,         // a program operation is running
  input  wire logic       ERS_ACTIVE,         // an erase operation is running
  input  wire logic       SUSPEND_REQ,        // suspend command pulse
  input  wire logic       RESUME_REQ,         // resume command pulse
  input  wire logic       IR_PGM_REQ,         // information row program request pulse
  input  wire logic [1:0] IR_PGM_ROW,         // information row addressed
  output logic            IR_PGM_GRANT,       // request allowed, one-cycle pulse
  output logic            IR_PGM_REFUSED,     // request refused, one-cycle pulse
  output logic [7:0]      FUNC_REG,           // function register contents
  output logic [7:0]      READ_PARAMS_NV,     // non-volatile read parameters
  output logic [7:0]      READ_PARAMS_V,      // volatile read parameters
  output logic            DEDICATED_RESET_EN, // dedicated reset pin is active
  output logic            SHARED_PIN_RESET,   // shared pin acts as reset
  output logic            SHARED_PIN_HOLD,    // shared pin acts as hold
  output logic            SHARED_PIN_DATA3,   // shared pin is data line 3
  output logic            WP_PIN_DATA2,       // write-protect pin is data line 2
  output logic            PROTECT_BOTTOM,     // block protection from the bottom
  output logic [3:0]      DUMMY_FAST_SPI,     // dummy cycles, single-line fast read
  output logic [3:0]      DUMMY_FAST_QPI,     // dummy cycles, quad command fast read
  output logic [6:0]      BURST_BYTES,        // burst length in bytes
  output logic            WRAP_IN_BURST       // wrap within burst, else at array end
);

  // link sampling and frame state
  logic [2:0] sync1_q;                  // first stage, read only by the second
  logic [2:0] sync2_q;                  // {si, ce_n, sck} synchronised
  logic       sck_prev_q;
  logic       sck_rise;
  logic       ce_act;
  ffrp_pkg::ffrp_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] opc_q;
  logic [7:0] data_q;
  logic       wr_done;
  logic [7:0] byte_in;
  // register state and next values
  logic [7:0] func_q;
  logic [7:0] rp_nv_q;
  logic [7:0] rp_v_q;
  logic       load_pend_q;
  logic       pgm_susp_d;
  logic       ers_susp_d;
  logic       data3_d;
  logic       reset_sel_d;
  logic [3:0] dummy_fld;

  // two-flop synchronisers for the host pins
  // a link bit lands up to three system cycles after its pin edge; the host
  // timing leaves SI settled for several cycles around every SCK rise
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
          sync1_q[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          sync2_q[gi] <= (gi == 1) ? 1'b1 : 1'b0;
        end else begin
          sync1_q[gi] <= (gi == 0) ? SCK : ((gi == 1) ? CE_N : SI);
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // edge detection looks only at the second stage
  // reset value matches the idle SCK level, so no false edge follows reset
  always_ff @(posedge CLK_SYS) begin
    if (RESET) sck_prev_q <= 1'b0;
    else       sck_prev_q <= sync2_q[0];
  end

  assign ce_act   = ~sync2_q[1];
  assign sck_rise = ce_act & sync2_q[0] & ~sck_prev_q;
  assign byte_in  = {data_q[6:0], sync2_q[2]};

  // frame sequencer: opcode byte, one data byte, then ignore the rest
  // a frame cut before its last data bit never reaches wr_done, and CE_N high
  // clears the sequencer, so no half-shifted byte can ever land
  always_ff @(posedge CLK_SYS) begin
    if (RESET || !ce_act) begin
      state_q   <= ffrp_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      opc_q     <= 8'h00;
      data_q    <= 8'h00;
    end else if (sck_rise) begin
      case (state_q)
        ffrp_pkg::ST_IDLE, ffrp_pkg::ST_OPC: begin
          opc_q     <= {opc_q[6:0], sync2_q[2]};
          bit_cnt_q <= bit_cnt_q + 4'h1;
          state_q   <= (bit_cnt_q == ffrp_pkg::BIT_OPC_LAST) ? ffrp_pkg::ST_DATA
                                                             : ffrp_pkg::ST_OPC;
        end
        ffrp_pkg::ST_DATA: begin
          data_q    <= byte_in;
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == ffrp_pkg::BIT_DATA_LAST) state_q <= ffrp_pkg::ST_SKIP;
        end
        default: state_q <= ffrp_pkg::ST_SKIP;
      endcase
    end
  end

  // a write lands on the rising edge carrying the last data bit
  assign wr_done = sck_rise && (state_q == ffrp_pkg::ST_DATA)
                   && (bit_cnt_q == ffrp_pkg::BIT_DATA_LAST);

  // suspend flags: a suspend in the same cycle as a resume wins
  // resume clears both flags, since only one operation can be suspended
  always_comb begin
    pgm_susp_d = func_q[ffrp_pkg::FN_PGM_SUSP];
    ers_susp_d = func_q[ffrp_pkg::FN_ERS_SUSP];
    if (RESUME_REQ) begin
      pgm_susp_d = 1'b0; // RULE_04
      ers_susp_d = 1'b0; // RULE_05
    end
    if (SUSPEND_REQ && PGM_ACTIVE) pgm_susp_d = 1'b1; // RULE_04
    if (SUSPEND_REQ && ERS_ACTIVE) ers_susp_d = 1'b1; // RULE_05
  end

  // function register: one-time bits can only be or-ed in
  // the suspend flags are status only; a link write leaves them alone
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      func_q <= {7'h00, DED_RESET_DIS_INIT}; // RULE_02
    end else begin
      func_q[ffrp_pkg::FN_PGM_SUSP] <= pgm_susp_d;
      func_q[ffrp_pkg::FN_ERS_SUSP] <= ers_susp_d;
      if (wr_done && opc_q == ffrp_pkg::OPC_WR_FUNC) begin
        // RULE_01 RULE_03 RULE_06
        func_q[1:0] <= func_q[1:0] | (byte_in[1:0] & ffrp_pkg::FN_OTP_MASK[1:0]);
        func_q[7:4] <= func_q[7:4] | (byte_in[7:4] & ffrp_pkg::FN_OTP_MASK[7:4]);
      end
    end
  end

  // non-volatile read parameters, written only by its own opcode
  always_ff @(posedge CLK_SYS) begin
    if (RESET) rp_nv_q <= ffrp_pkg::RP_RESET; // RULE_16
    else if (wr_done && opc_q == ffrp_pkg::OPC_SET_RP_NV) rp_nv_q <= byte_in; // RULE_11
  end

  // volatile copy: loaded once after power-up, then by its two opcodes
  // the load takes the first edge after reset, long before any frame can finish
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rp_v_q      <= ffrp_pkg::RP_RESET; // RULE_16
      load_pend_q <= 1'b1;
    end else begin
      load_pend_q <= 1'b0;
      if (load_pend_q) rp_v_q <= rp_nv_q; // RULE_07
      else if (wr_done && (opc_q == ffrp_pkg::OPC_SET_RP_V_A ||
                           opc_q == ffrp_pkg::OPC_SET_RP_V_B))
        rp_v_q <= byte_in; // RULE_11 RULE_18
    end
  end

  // pin functions derive from the volatile copy only
  // quad use overrides every control role of the shared and write-protect pins
  assign data3_d   = QUAD_ENABLE | QUAD_CMD_MODE; // RULE_09 RULE_17
  // a still-enabled dedicated reset pin pins the shared pin to hold
  assign reset_sel_d = ~data3_d & rp_v_q[ffrp_pkg::RP_PIN_SEL] // RULE_08
                       & ~(HAS_DEDICATED_RESET & ~func_q[ffrp_pkg::FN_DED_RST_DIS]); // RULE_10
  assign dummy_fld = rp_v_q[ffrp_pkg::RP_DUMMY_HI:ffrp_pkg::RP_DUMMY_LO];

  // registered pin-function and block-protection outputs
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      DEDICATED_RESET_EN <= 1'b0;
      SHARED_PIN_RESET   <= 1'b0;
      SHARED_PIN_HOLD    <= 1'b0;
      SHARED_PIN_DATA3   <= 1'b0;
      WP_PIN_DATA2       <= 1'b0;
      PROTECT_BOTTOM     <= 1'b0;
    end else begin
      DEDICATED_RESET_EN <= HAS_DEDICATED_RESET & ~func_q[ffrp_pkg::FN_DED_RST_DIS]; // RULE_02
      SHARED_PIN_RESET   <= reset_sel_d;
      SHARED_PIN_HOLD    <= ~data3_d & ~reset_sel_d; // RULE_10
      SHARED_PIN_DATA3   <= data3_d; // RULE_17
      WP_PIN_DATA2       <= data3_d; // RULE_17
      PROTECT_BOTTOM     <= func_q[ffrp_pkg::FN_TOP_BOTTOM]; // RULE_03
    end
  end

  // dummy, burst and wrap settings from the volatile copy
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      DUMMY_FAST_SPI <= ffrp_pkg::DUMMY_DEF_FAST_SPI;
      DUMMY_FAST_QPI <= ffrp_pkg::DUMMY_DEF_FAST_QPI;
      BURST_BYTES    <= ffrp_pkg::BURST_BASE;
      WRAP_IN_BURST  <= 1'b0;
    end else begin
      // RULE_12 RULE_13
      DUMMY_FAST_SPI <= (dummy_fld == ffrp_pkg::DUMMY_ZERO) ? ffrp_pkg::DUMMY_DEF_FAST_SPI
                                                           : dummy_fld;
      DUMMY_FAST_QPI <= (dummy_fld == ffrp_pkg::DUMMY_ZERO) ? ffrp_pkg::DUMMY_DEF_FAST_QPI
                                                           : dummy_fld;
      BURST_BYTES    <= ffrp_pkg::BURST_BASE
                        << rp_v_q[ffrp_pkg::RP_BURST_HI:ffrp_pkg::RP_BURST_LO]; // RULE_14
      WRAP_IN_BURST  <= rp_v_q[ffrp_pkg::RP_WRAP]; // RULE_15
    end
  end

  // register mirrors
  // mirrors let the rest of the device see the registers without a read-back path
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      FUNC_REG       <= 8'h00;
      READ_PARAMS_NV <= ffrp_pkg::RP_RESET;
      READ_PARAMS_V  <= ffrp_pkg::RP_RESET;
    end else begin
      FUNC_REG       <= func_q;
      READ_PARAMS_NV <= rp_nv_q;
      READ_PARAMS_V  <= rp_v_q;
    end
  end

  // information row program gate; the row itself lives elsewhere
  // the lock is taken from the register before the edge, so a lock landing in
  // the same cycle as a request does not refuse that request
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      IR_PGM_GRANT   <= 1'b0;
      IR_PGM_REFUSED <= 1'b0;
    end else begin
      IR_PGM_GRANT   <= IR_PGM_REQ & ~func_q[ffrp_pkg::FN_IR_LOCK_LO + IR_PGM_ROW]; // RULE_19
      IR_PGM_REFUSED <= IR_PGM_REQ & func_q[ffrp_pkg::FN_IR_LOCK_LO + IR_PGM_ROW];  // RULE_06
    end
  end

  // function register checks
  a_otp_sticky: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_01
    ($past(func_q) & ffrp_pkg::FN_OTP_MASK & ~func_q) == 8'h00)
    else $error("otp bit of function register cleared");
  a_otp_never_clear: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_03
    $past(func_q[ffrp_pkg::FN_TOP_BOTTOM]) |-> func_q[ffrp_pkg::FN_TOP_BOTTOM])
    else $error("bottom select returned to top");
  a_pgm_susp_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_04
    SUSPEND_REQ && PGM_ACTIVE |=> func_q[ffrp_pkg::FN_PGM_SUSP])
    else $error("program suspend flag not set");
  a_ers_susp_clr: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_05
    RESUME_REQ && !(SUSPEND_REQ && ERS_ACTIVE) |=> !func_q[ffrp_pkg::FN_ERS_SUSP])
    else $error("erase suspend flag not cleared on resume");
  a_pgm_susp_clr: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_04
    RESUME_REQ && !(SUSPEND_REQ && PGM_ACTIVE) |=> !func_q[ffrp_pkg::FN_PGM_SUSP])
    else $error("program suspend flag not cleared on resume");
  a_ers_susp_set: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_05
    SUSPEND_REQ && ERS_ACTIVE |=> func_q[ffrp_pkg::FN_ERS_SUSP])
    else $error("erase suspend flag not set");
  a_ded_reset_off: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_02
    func_q[ffrp_pkg::FN_DED_RST_DIS] |=> !DEDICATED_RESET_EN)
    else $error("dedicated reset pin still active after disable");

  // read-parameter copy checks
  a_vol_load: assert property (@(posedge CLK_SYS) // RULE_07
    $fell(RESET) ##1 !RESET |-> rp_v_q == $past(rp_nv_q))
    else $error("volatile copy not loaded after power-up");
  a_nv_only_cmd: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_18
    !$stable(rp_nv_q) |-> $past(wr_done) && $past(opc_q) == ffrp_pkg::OPC_SET_RP_NV)
    else $error("non-volatile copy changed without its opcode");
  a_v_only_cmd: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_11
    !$stable(rp_v_q) && !$past(load_pend_q) |->
      $past(wr_done) && ($past(opc_q) == ffrp_pkg::OPC_SET_RP_V_A ||
                         $past(opc_q) == ffrp_pkg::OPC_SET_RP_V_B))
    else $error("volatile copy changed without its opcode");

  // pin role checks
  a_data3_quad: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_09
    QUAD_ENABLE |=> SHARED_PIN_DATA3 && !SHARED_PIN_RESET && !SHARED_PIN_HOLD)
    else $error("shared pin not data line with quad enable");
  a_qpi_data3: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_09
    QUAD_CMD_MODE |=> SHARED_PIN_DATA3 && WP_PIN_DATA2 && !SHARED_PIN_RESET)
    else $error("shared pin not data line in quad command mode");
  a_hold_forced: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_10
    HAS_DEDICATED_RESET && !func_q[ffrp_pkg::FN_DED_RST_DIS] && !data3_d |=> SHARED_PIN_HOLD)
    else $error("hold not forced while dedicated reset enabled");
  a_reset_select: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_08
    !data3_d && rp_v_q[ffrp_pkg::RP_PIN_SEL] && func_q[ffrp_pkg::FN_DED_RST_DIS]
      |=> SHARED_PIN_RESET && !SHARED_PIN_HOLD)
    else $error("shared pin not reset with its select set");
  a_hold_select: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_08
    !data3_d && !rp_v_q[ffrp_pkg::RP_PIN_SEL] |=> SHARED_PIN_HOLD && !SHARED_PIN_RESET)
    else $error("shared pin not hold with its select clear");

  // read control checks
  a_dummy_default: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_13
    dummy_fld == ffrp_pkg::DUMMY_ZERO |=> DUMMY_FAST_SPI == ffrp_pkg::DUMMY_DEF_FAST_SPI
      && DUMMY_FAST_QPI == ffrp_pkg::DUMMY_DEF_FAST_QPI)
    else $error("default dummy counts wrong");
  a_dummy_field: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_12
    dummy_fld != ffrp_pkg::DUMMY_ZERO |=> DUMMY_FAST_SPI == $past(dummy_fld)
      && DUMMY_FAST_QPI == $past(dummy_fld))
    else $error("programmed dummy count not applied");
  a_wrap_follow: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_15
    rp_v_q[ffrp_pkg::RP_WRAP] |=> WRAP_IN_BURST)
    else $error("wrap within burst not applied");

  // information row checks
  a_ir_lock: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_19
    IR_PGM_REQ && func_q[ffrp_pkg::FN_IR_LOCK_LO + IR_PGM_ROW] |=> !IR_PGM_GRANT && IR_PGM_REFUSED)
    else $error("program granted to locked information row");
  a_ir_open: assert property (@(posedge CLK_SYS) disable iff (RESET) // RULE_06
    IR_PGM_REQ && !func_q[ffrp_pkg::FN_IR_LOCK_LO + IR_PGM_ROW]
      |=> IR_PGM_GRANT && !IR_PGM_REFUSED)
    else $error("program refused to open information row");

  // main scenarios
  c_nv_write: cover property (@(posedge CLK_SYS) wr_done && opc_q == ffrp_pkg::OPC_SET_RP_NV);
  c_v_write: cover property (@(posedge CLK_SYS) wr_done && opc_q == ffrp_pkg::OPC_SET_RP_V_B);
  c_func_write: cover property (@(posedge CLK_SYS) wr_done && opc_q == ffrp_pkg::OPC_WR_FUNC);
  c_suspend: cover property (@(posedge CLK_SYS) SUSPEND_REQ && PGM_ACTIVE ##[1:50] RESUME_REQ);
  c_ers_suspend: cover property (@(posedge CLK_SYS) SUSPEND_REQ && ERS_ACTIVE ##[1:50] RESUME_REQ);

endmodule : ffrp_regs

/* testbench/ffrp_host_model.sv */
// partner model: single-line serial host sending opcode plus data frames
// assumes the device samples the link with its own much faster clock
`timescale 1ns/100ps
module ffrp_host_model (
  output logic sck,  // serial clock, held low outside frames
  output logic ce_n, // chip enable, active low
  output logic si    // serial data, msb first
);
  // idle link: clock still, chip not selected
  initial begin
    sck  = 1'b0;
    ce_n = 1'b1;
    si   = 1'b1;
  end

  // one frame of nbits; fewer than 16 bits cuts the frame short
  task automatic send(input logic [7:0] opc, input logic [7:0] dat, input int nbits);
    logic [15:0] frm;
    frm = {opc, dat};
    #130 ce_n = 1'b0; // odd offset keeps the link out of phase with the system clock
    for (int i = 0; i < nbits; i++) begin
      si = frm[15 - i];
      #400 sck = 1'b1;
      #400 sck = 1'b0;
    end
    #400 ce_n = 1'b1;
    si = ~si; // a released line must not show the last bit
    #400;
  endtask : send
endmodule : ffrp_host_model

/* testbench/tb_flash_function_read_param_regs.sv */
// self-checking bench for the function and read-parameter register block
// assumes the serial host model drives the link; all else driven here
`timescale 1ns/100ps
module tb_flash_function_read_param_regs;
  typedef struct packed {
    logic [7:0] opc, dat, nv, v;
    logic [3:0] ds, dq;
    logic [6:0] bb;
    logic       wr;
  } ffrp_row_t;
  // opcode, data, then expected nv, v, dummy spi/qpi, burst bytes, wrap
  localparam ffrp_row_t ROWS [6] = '{
    '{8'hc0, 8'h00, 8'h00, 8'h00, 4'h8, 4'h6, 7'h08, 1'b0},
    '{8'h63, 8'h07, 8'h00, 8'h07, 4'h8, 4'h6, 7'h40, 1'b1},
    '{8'hc0, 8'h7a, 8'h00, 8'h7a, 4'hf, 4'hf, 7'h20, 1'b0},
    '{8'h63, 8'h09, 8'h00, 8'h09, 4'h1, 4'h1, 7'h10, 1'b0},
    '{8'h65, 8'h55, 8'h55, 8'h09, 4'h1, 4'h1, 7'h10, 1'b0},
    '{8'h66, 8'hff, 8'h55, 8'h09, 4'h1, 4'h1, 7'h10, 1'b0}};
  logic       clk_sys, reset, sck, ce_n, si, qe, quad_command_mode, pgm_act, ers_act;
  logic       susp, resume, ir_req, ir_grant, ir_refused, ded_en, pin_rst;
  logic       pin_hold, pin_d3, wp_d2, prot_bot, wrap;
  logic [1:0] ir_row;
  logic [7:0] func_reg, rp_nv, rp_v;
  logic [3:0] dummy_spi, dummy_qpi;
  logic [6:0] burst;
  int         miscompares, comparisons;

  ffrp_host_model i_ffrp_host_model (.sck(sck), .ce_n(ce_n), .si(si));
  ffrp_regs i_ffrp_regs (
    .CLK_SYS(clk_sys), .RESET(reset), .SCK(sck), .CE_N(ce_n), .SI(si),
    .QUAD_ENABLE(qe), .QUAD_CMD_MODE(quad_command_mode), .PGM_ACTIVE(pgm_act), .ERS_ACTIVE(ers_act),
    .SUSPEND_REQ(susp), .RESUME_REQ(resume), .IR_PGM_REQ(ir_req), .IR_PGM_ROW(ir_row),
    .IR_PGM_GRANT(ir_grant), .IR_PGM_REFUSED(ir_refused), .FUNC_REG(func_reg),
    .READ_PARAMS_NV(rp_nv), .READ_PARAMS_V(rp_v), .DEDICATED_RESET_EN(ded_en),
    .SHARED_PIN_RESET(pin_rst), .SHARED_PIN_HOLD(pin_hold), .SHARED_PIN_DATA3(pin_d3),
    .WP_PIN_DATA2(wp_d2), .PROTECT_BOTTOM(prot_bot), .DUMMY_FAST_SPI(dummy_spi),
    .DUMMY_FAST_QPI(dummy_qpi), .BURST_BYTES(burst), .WRAP_IN_BURST(wrap));

  // 10 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // wait n edges, then step off the edge before driving
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask : tick

  task automatic frame(input logic [7:0] opc, input logic [7:0] dat);
    i_ffrp_host_model.send(opc, dat, 16);
    tick(1);
  endtask : frame

  // pin roles packed as reset, hold, data3, wp data2, dedicated reset enable
  task automatic pins(input logic [7:0] exp);
    chk({3'h0, pin_rst, pin_hold, pin_d3, wp_d2, ded_en}, exp);
  endtask : pins

  // a hung handshake must not stall the run
  initial begin
    #2000000;
    miscompares++;
    end_sim();
  end

  initial begin
    {qe, quad_command_mode, pgm_act, ers_act, susp, resume, ir_req, ir_row} = '0;
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(3);
    chk(func_reg, 8'h00);
    chk(rp_v, 8'h00);
    chk({dummy_spi, 1'b0, burst[6:4]}, 8'h80);
    pins(8'h09);
    // ordinary parameter writes and a last row with unknown opcode 66h, one frame per row
    for (int i = 0; i < $size(ROWS); i++) begin
      frame(ROWS[i].opc, ROWS[i].dat);
      chk(rp_nv, ROWS[i].nv);
      chk(rp_v, ROWS[i].v);
      chk({dummy_spi, dummy_qpi}, {ROWS[i].ds, ROWS[i].dq});
      chk({1'b0, burst}, {1'b0, ROWS[i].bb});
      chk({7'h0, wrap}, {7'h0, ROWS[i].wr});
    end
    // a frame cut before its data byte ends changes nothing
    i_ffrp_host_model.send(8'hc0, 8'h00, 12);
    tick(1);
    chk(rp_v, 8'h09);
    // shared pin roles
    frame(8'hc0, 8'h80);
    pins(8'h09);
    qe = 1'b1;
    tick(3);
    pins(8'h07);
    qe = 1'b0;
    quad_command_mode = 1'b1;
    tick(3);
    pins(8'h07);
    quad_command_mode = 1'b0;
    frame(8'h42, 8'h01);
    pins(8'h10);
    frame(8'hc0, 8'h00);
    pins(8'h08);
    // one-time bits and information row locks, back-to-back requests
    frame(8'h42, 8'h12);
    chk({7'h0, prot_bot}, 8'h01);
    ir_row = 2'h0;
    ir_req = 1'b1;
    tick(1);
    ir_row = 2'h1;
    chk({6'h0, ir_grant, ir_refused}, 8'h01);
    tick(1);
    ir_req = 1'b0;
    chk({6'h0, ir_grant, ir_refused}, 8'h02);
    frame(8'h42, 8'hec);
    chk(func_reg, 8'hf3);
    frame(8'h42, 8'h00);
    chk(func_reg, 8'hf3);
    // suspend during program, during erase, and with nothing running
    for (int k = 0; k < 3; k++) begin
      pgm_act = (k == 0);
      ers_act = (k == 1);
      susp = 1'b1;
      tick(1);
      susp = 1'b0;
      tick(1);
      chk(func_reg, (k < 2) ? (8'hf3 | (8'h04 << k)) : 8'hf3);
      resume = 1'b1;
      tick(1);
      resume = 1'b0;
      tick(1);
      chk(func_reg, 8'hf3);
    end
    end_sim();
  end
endmodule : tb_flash_function_read_param_regs
